// ==== design/mmrs_pkg.sv ====
// package: constants and types of the module management and rate select block
package mmrs_pkg;

    // clock and start-up timing
    localparam int unsigned CLK_HZ      = 50_000_000;        // system clock rate
    localparam int unsigned INIT_TIME_S = 10;                // longest start-up time, s
    localparam int unsigned INIT_CYCLES = INIT_TIME_S * CLK_HZ; // rounded down

    // two-wire device addresses (7-bit part, r/w bit dropped)
    localparam logic [6:0] ID_DEV_ADDR   = 7'h50;            // identification map
    localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;            // diagnostics map

    // identification map
    localparam logic [7:0] ID_BYTE0_RESET = 8'h5c;           // type code in byte 0, arbitrary

    // diagnostics map layout
    localparam logic [7:0] THR_END        = 8'h28;           // thresholds 0x00..0x27
    localparam logic [7:0] MON_BASE       = 8'h60;           // live values 0x60..0x69
    localparam logic [7:0] MON_END        = 8'h6a;
    localparam logic [7:0] ALARM_BASE     = 8'h70;           // alarm flags 0x70..0x71
    localparam logic [7:0] WARN_BASE      = 8'h74;           // warning flags 0x74..0x75
    localparam logic [7:0] USER_BASE      = 8'h80;           // user area 0x80..0xff
    localparam logic [7:0] RATE_SOFT_LO   = 8'h6e;           // rate_select_soft_lo
    localparam logic [7:0] RATE_SOFT_HI   = 8'h76;           // rate_select_soft_hi
    localparam int unsigned RATE_SOFT_BIT = 3;               // soft rate bit position
    localparam logic [7:0] RATE_SOFT_RESET = 8'h08;          // soft rate bit set at power-up

    // factory thresholds per value: alarm hi, alarm lo, warn hi, warn lo
    localparam int unsigned   MON_COUNT   = 5;
    localparam logic [63:0]   THR_ONE     = 64'hc000_1000_b000_2000;
    localparam logic [319:0]  THR_RESET   = {5{THR_ONE}};

    // live monitor values from the diag_monitor_controller
    typedef struct packed {
        logic [15:0] temp;                                   // module temperature
        logic [15:0] vcc;                                    // supply voltage
        logic [15:0] bias;                                   // laser bias current
        logic [15:0] tx_pwr;                                 // transmit optical power
        logic [15:0] rx_pwr;                                 // receive optical power
    } mmrs_mon_t;

    // clock-recovery locking modes
    typedef enum logic [1:0] {
        CDR_LOCK_8G5,
        CDR_LOCK_10G,
        CDR_BYPASS
    } mmrs_cdr_mode_t;

    typedef struct packed {
        mmrs_cdr_mode_t tx;                                  // transmit unit mode
        mmrs_cdr_mode_t rx;                                  // receive unit mode
    } mmrs_cdr_t;

endpackage

// ==== design/mmrs_top.sv ====
// module: two-wire management slave, diagnostics flags and rate select
`timescale 1ns/10ps
module mmrs_top #(
    parameter int unsigned INIT_CYCLES = mmrs_pkg::INIT_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe,
    input  wire logic              rate_pin_lo,
    input  wire logic              rate_pin_hi,
    input  wire logic              low_power_req,
    input  wire mmrs_pkg::mmrs_mon_t mon,
    output mmrs_pkg::mmrs_cdr_t    cdr_mode,
    output logic                   traffic_en,
    output logic                   init_done
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] scl_s;                     // scl through two flops
    logic [1:0] sda_s;                     // sda through two flops
    logic [1:0] rlo_s;                     // rate_pin_lo synchroniser
    logic [1:0] rhi_s;                     // rate_pin_hi synchroniser
    logic [1:0] lp_s;                      // low_power_req synchroniser
    logic       scl_d;                     // last synced scl, for edges
    logic       sda_d;                     // last synced sda, for edges

    // first flops read only by second flops; bus lines idle high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            rlo_s <= 2'h0;
            rhi_s <= 2'h0;
            lp_s  <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            rlo_s <= {rlo_s[0], rate_pin_lo};
            rhi_s <= {rhi_s[0], rate_pin_hi};
            lp_s  <= {lp_s[0], low_power_req};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end

    // edges and framing seen at the system clock
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = scl_s[1] & ~scl_d;
    assign scl_fall  = ~scl_s[1] & scl_d;
    assign bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    assign bus_stop  = scl_s[1] & scl_d & ~sda_d & sda_s[1];

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] id_mem   [0:255];          // identification map, factory content
    logic [7:0] diag_mem [0:255];          // thresholds and user area
    logic [7:0] soft_lo;                   // rate_select_soft_lo
    logic [7:0] soft_hi;                   // rate_select_soft_hi
    logic [7:0] alarm_b0;                  // alarm flags, first byte
    logic [7:0] alarm_b1;                  // alarm flags, second byte
    logic [7:0] warn_b0;                   // warning flags, first byte
    logic [7:0] warn_b1;                   // warning flags, second byte

    ////////////////////////////////////////////////////////////////////////////
    // slave state
    typedef enum logic [3:0] {
        S_IDLE, S_DEV, S_DEV_ACK, S_ADDR, S_ADDR_ACK,
        S_WR, S_WR_ACK, S_RD, S_RD_ACK
    } mmrs_state_t;

    mmrs_state_t state;                    // bus sequencer state
    logic [3:0]  bit_cnt;                  // bits moved in current byte
    logic [7:0]  shift_in;                 // received bits
    logic [7:0]  shift_out;                // bits still to send
    logic        sel_diag;                 // 1: diagnostics map addressed
    logic        rd_mode;                  // r/w bit of the address byte
    logic        host_nack;                // host refused further bytes
    logic [7:0]  ptr;                      // current word pointer
    logic        wr_stb;                   // one-cycle write of shift_in at ptr
    logic        ptr_inc;                  // one-cycle pointer advance
    logic        ptr_load;                 // one-cycle pointer load

    ////////////////////////////////////////////////////////////////////////////
    // read data path: live values and flags come from logic, not memory
    logic [79:0] mon_flat;
    logic [7:0]  mon_idx;
    logic [7:0]  rd_data;
    assign mon_flat = mon;
    assign mon_idx  = ptr - mmrs_pkg::MON_BASE;

    always_comb begin
        rd_data = id_mem[ptr];
        if (sel_diag) begin
            if (ptr >= mmrs_pkg::MON_BASE && ptr < mmrs_pkg::MON_END) begin
                rd_data = mon_flat[8'd79 - {mon_idx[6:0], 3'h0} -: 8];
            end else if (ptr == mmrs_pkg::ALARM_BASE) begin
                rd_data = alarm_b0;
            end else if (ptr == mmrs_pkg::ALARM_BASE + 8'h01) begin
                rd_data = alarm_b1;
            end else if (ptr == mmrs_pkg::WARN_BASE) begin
                rd_data = warn_b0;
            end else if (ptr == mmrs_pkg::WARN_BASE + 8'h01) begin
                rd_data = warn_b1;
            end else if (ptr == mmrs_pkg::RATE_SOFT_LO) begin
                rd_data = soft_lo;
            end else if (ptr == mmrs_pkg::RATE_SOFT_HI) begin
                rd_data = soft_hi;
            end else begin
                rd_data = diag_mem[ptr];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus sequencer: samples on scl rise, changes sda on scl fall
    always_ff @(posedge clk) begin
        wr_stb   <= 1'b0;
        ptr_inc  <= 1'b0;
        ptr_load <= 1'b0;
        if (sys_rst) begin
            state     <= S_IDLE;
            bit_cnt   <= 4'h0;
            shift_in  <= 8'h00;
            shift_out <= 8'h00;
            sel_diag  <= 1'b0;
            rd_mode   <= 1'b0;
            host_nack <= 1'b0;
            sda_oe    <= 1'b0;
        end else if (bus_stop) begin
            state  <= S_IDLE;
            sda_oe <= 1'b0;
        end else if (bus_start) begin
            state   <= S_DEV;              // repeated start too
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (scl_rise) begin
            // host bits are taken on the rising edge
            case (state)
                S_DEV, S_ADDR, S_WR: begin
                    shift_in <= {shift_in[6:0], sda_s[1]};
                    bit_cnt  <= bit_cnt + 4'h1;
                end
                S_RD_ACK: host_nack <= sda_s[1];
                default: ;
            endcase
        end else if (scl_fall) begin
            // own bits and acks change only while scl is low
            case (state)
                S_DEV: if (bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h0;
                    if (shift_in[7:1] == mmrs_pkg::ID_DEV_ADDR ||
                        shift_in[7:1] == mmrs_pkg::DIAG_DEV_ADDR) begin
                        sel_diag <= shift_in[1];
                        rd_mode  <= shift_in[0];
                        sda_oe   <= 1'b1;     // ack
                        state    <= S_DEV_ACK;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_DEV_ACK: begin
                    if (rd_mode) begin
                        shift_out <= rd_data;
                        sda_oe    <= ~rd_data[7];
                        bit_cnt   <= 4'h1;
                        state     <= S_RD;
                    end else begin
                        sda_oe <= 1'b0;
                        state  <= S_ADDR;
                    end
                end
                S_ADDR: if (bit_cnt == 4'h8) begin
                    ptr_load <= 1'b1;
                    sda_oe   <= 1'b1;
                    state    <= S_ADDR_ACK;
                end
                S_ADDR_ACK: begin
                    sda_oe  <= 1'b0;
                    bit_cnt <= 4'h0;
                    state   <= S_WR;
                end
                S_WR: if (bit_cnt == 4'h8) begin
                    wr_stb <= 1'b1;
                    sda_oe <= 1'b1;
                    state  <= S_WR_ACK;
                end
                S_WR_ACK: begin
                    sda_oe  <= 1'b0;
                    bit_cnt <= 4'h0;
                    state   <= S_WR;
                end
                S_RD: begin
                    if (bit_cnt == 4'h8) begin
                        sda_oe  <= 1'b0;   // release for the host ack
                        ptr_inc <= 1'b1;
                        state   <= S_RD_ACK;
                    end else begin
                        sda_oe    <= ~shift_out[6];
                        shift_out <= {shift_out[6:0], 1'b0};
                        bit_cnt   <= bit_cnt + 4'h1;
                    end
                end
                S_RD_ACK: begin
                    if (host_nack) begin
                        state <= S_IDLE;
                    end else begin
                        shift_out <= rd_data;
                        sda_oe    <= ~rd_data[7];
                        bit_cnt   <= 4'h1;
                        state     <= S_RD;
                    end
                end
                default: ;
            endcase
        end
    end

    // only low is ever driven: the line is open-drain
    always_ff @(posedge clk) begin
        sda_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // word pointer: loads from the address byte, advances after each word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr <= 8'h00;
        end else if (ptr_load) begin
            ptr <= shift_in;
        end else if (ptr_inc || wr_stb) begin
            ptr <= ptr + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory writes: identification map and thresholds are write-protected
    logic user_wr;
    assign user_wr = wr_stb && sel_diag && ptr >= mmrs_pkg::USER_BASE;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 256; i++) begin
                id_mem[i]   <= 8'h00;
                diag_mem[i] <= 8'h00;
            end
            id_mem[0] <= mmrs_pkg::ID_BYTE0_RESET;
            for (int i = 0; i < 40; i++) begin
                diag_mem[i] <= mmrs_pkg::THR_RESET[319 - 8*i -: 8];
            end
        end else if (user_wr) begin
            diag_mem[ptr] <= shift_in;
        end
    end

    // soft rate registers: set at power-up, host may rewrite
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            soft_lo <= mmrs_pkg::RATE_SOFT_RESET;
            soft_hi <= mmrs_pkg::RATE_SOFT_RESET;
        end else if (wr_stb && sel_diag) begin
            if (ptr == mmrs_pkg::RATE_SOFT_LO) begin
                soft_lo <= shift_in;
            end else if (ptr == mmrs_pkg::RATE_SOFT_HI) begin
                soft_hi <= shift_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // threshold compare, one per monitored value, in value order
    logic [4:0] a_hi;                      // above high alarm
    logic [4:0] a_lo;                      // below low alarm
    logic [4:0] w_hi;                      // above high warning
    logic [4:0] w_lo;                      // below low warning

    for (genvar g = 0; g < mmrs_pkg::MON_COUNT; g++) begin : g_cmp
        logic [15:0] val;
        logic [15:0] thr_ah;
        logic [15:0] thr_al;
        logic [15:0] thr_wh;
        logic [15:0] thr_wl;
        assign val    = mon_flat[79 - 16*g -: 16];
        assign thr_ah = {diag_mem[8*g],     diag_mem[8*g + 1]};
        assign thr_al = {diag_mem[8*g + 2], diag_mem[8*g + 3]};
        assign thr_wh = {diag_mem[8*g + 4], diag_mem[8*g + 5]};
        assign thr_wl = {diag_mem[8*g + 6], diag_mem[8*g + 7]};
        assign a_hi[4 - g] = val > thr_ah;
        assign a_lo[4 - g] = val < thr_al;
        assign w_hi[4 - g] = val > thr_wh;
        assign w_lo[4 - g] = val < thr_wl;
    end

    // flags follow the live values; hi/lo pairs packed from bit 7 down
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alarm_b0 <= 8'h00;
            alarm_b1 <= 8'h00;
            warn_b0  <= 8'h00;
            warn_b1  <= 8'h00;
        end else begin
            alarm_b0 <= {a_hi[4], a_lo[4], a_hi[3], a_lo[3],
                         a_hi[2], a_lo[2], a_hi[1], a_lo[1]};
            alarm_b1 <= {a_hi[0], a_lo[0], 6'h00};
            warn_b0  <= {w_hi[4], w_lo[4], w_hi[3], w_lo[3],
                         w_hi[2], w_lo[2], w_hi[1], w_lo[1]};
            warn_b1  <= {w_hi[0], w_lo[0], 6'h00};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // effective rate bits and clock-recovery modes
    logic eff_lo;
    logic eff_hi;
    assign eff_lo = rlo_s[1] | soft_lo[mmrs_pkg::RATE_SOFT_BIT];
    assign eff_hi = rhi_s[1] | soft_hi[mmrs_pkg::RATE_SOFT_BIT];

    // mode follows pins three cycles and soft bits one cycle after a change
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cdr_mode.tx <= mmrs_pkg::CDR_LOCK_10G;
            cdr_mode.rx <= mmrs_pkg::CDR_LOCK_10G;
        end else begin
            case ({eff_lo, eff_hi})
                2'h0: begin
                    cdr_mode.tx <= mmrs_pkg::CDR_LOCK_8G5;
                    cdr_mode.rx <= mmrs_pkg::CDR_LOCK_8G5;
                end
                2'h1: begin
                    cdr_mode.tx <= mmrs_pkg::CDR_BYPASS;
                    cdr_mode.rx <= mmrs_pkg::CDR_LOCK_10G;
                end
                2'h2: begin
                    cdr_mode.tx <= mmrs_pkg::CDR_BYPASS;
                    cdr_mode.rx <= mmrs_pkg::CDR_BYPASS;
                end
                default: begin
                    cdr_mode.tx <= mmrs_pkg::CDR_LOCK_10G;
                    cdr_mode.rx <= mmrs_pkg::CDR_LOCK_10G;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up: the bus works at once, traffic waits for the init count
    logic [31:0] init_cnt;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            init_cnt  <= 32'h0;
            init_done <= 1'b0;
        end else if (!init_done) begin
            init_cnt <= init_cnt + 32'h1;
            if (init_cnt >= INIT_CYCLES - 32'h1) begin
                init_done <= 1'b1;
            end
        end
    end

    // no power-level handshake needed; low power only stops traffic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            traffic_en <= 1'b0;
        end else begin
            traffic_en <= init_done & ~lp_s[1];
        end
    end

endmodule // mmrs_top

// ==== tb/mmrs_host.sv ====
// host controller model: drives the two-wire bus from the board side
`timescale 1ns/10ps
module mmrs_host (
    input  wire logic clk,      // time base only
    input  wire logic sda,      // resolved data line level
    output logic      scl,      // two-wire clock, host owned
    output logic      sda_drv   // 0 pulls data low, 1 releases to pull-up
);
    // idle: both lines released, clock stands high between frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // half of the 160 ns link period, counted on clk falling edges
    task automatic half();
        repeat (4) @(negedge clk);
    endtask
    // one bit: data moves only while the clock is low, sampled late in high
    task automatic bit_x(input logic b, output logic r);
        sda_drv = b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask
    // start or repeated start: data falls while clock is high
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
    endtask
    // stop: data rises while clock is high, then both stay released
    task automatic stop();
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask
    // eight bits msb first plus the ninth acknowledge bit
    task automatic xbyte(input logic [7:0] d, input logic mack,
                         output logic [7:0] q, output logic nack);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(mack, nack);
    endtask
    // write two bytes, or set the pointer and read two bytes in sequence
    task automatic access(input logic [6:0] dev, input logic [7:0] addr,
                          input logic rd, input logic [7:0] wd,
                          output logic [15:0] rdat, output logic ok);
        logic [7:0] q;
        logic n0, n1, n2, nx;
        start();
        xbyte({dev, 1'b0}, 1'b1, q, n0);
        xbyte(addr, 1'b1, q, n1);
        if (rd) begin
            start();
            xbyte({dev, 1'b1}, 1'b1, q, n2);
            xbyte(8'hff, 1'b0, rdat[15:8], nx);
            xbyte(8'hff, 1'b1, rdat[7:0], nx);
        end else begin
            xbyte(wd, 1'b1, q, n2);
            xbyte(~wd, 1'b1, q, nx);
        end
        stop();
        ok = !n0 && !n1 && !n2;
    endtask
endmodule // mmrs_host

// ==== tb/mmrs_assertions.sv ====
// checker: timing and mode relations at the ports of mmrs_top
`timescale 1ns/10ps
module mmrs_assertions #(
    parameter int unsigned INIT_CYCLES = 20
) (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                scl_i,
    input wire logic                sda_o,
    input wire logic                sda_oe,
    input wire logic                rate_pin_lo,
    input wire logic                rate_pin_hi,
    input wire logic                low_power_req,
    input wire mmrs_pkg::mmrs_cdr_t cdr_mode,
    input wire logic                traffic_en,
    input wire logic                init_done
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] cyc;   // cycles since reset, saturating so it never wraps
    always_ff @(posedge clk) begin
        if (sys_rst) cyc <= 32'h0;
        else if (cyc != 32'hffff_ffff) cyc <= cyc + 32'h1;
    end
    ////////////////////////////////////////////////////////////////////////////
    reset_mode_a: assert property ($fell(sys_rst) |-> !init_done &&
        cdr_mode == {mmrs_pkg::CDR_LOCK_10G, mmrs_pkg::CDR_LOCK_10G})
        else $error("mode after reset is not 10G on both units");
    sda_low_a: assert property (sda_oe |-> sda_o == 1'b0)
        else $error("data line driven high");
    traffic_init_a: assert property (traffic_en |-> init_done)
        else $error("traffic before start-up ends");
    low_power_a: assert property (low_power_req [*5] |-> !traffic_en)
        else $error("traffic while in low power");
    init_bound_a: assert property ((!low_power_req [*6]) ##0
        (cyc > INIT_CYCLES + 4) |-> init_done && traffic_en)
        else $error("start-up not finished in time");
    mode_table_a: assert property (cdr_mode.rx == cdr_mode.tx ||
        cdr_mode == {mmrs_pkg::CDR_BYPASS, mmrs_pkg::CDR_LOCK_10G})
        else $error("illegal locking mode pair");
    pins_both_a: assert property ((rate_pin_lo && rate_pin_hi) [*6] |->
        cdr_mode == {mmrs_pkg::CDR_LOCK_10G, mmrs_pkg::CDR_LOCK_10G})
        else $error("both pins high but not 10G");
    pin_hi_a: assert property (rate_pin_hi [*6] |-> cdr_mode.rx == mmrs_pkg::CDR_LOCK_10G)
        else $error("receive unit not 10G with high pin");
    launch_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_i) && !$past(scl_i, 2))
        else $error("data launched outside clock low phase");
endmodule // mmrs_assertions

// ==== tb/tb.sv ====
// testbench: host transactions, rate select table, monitor flags, low power
`timescale 1ns/10ps
module tb;
    logic                clk = 1'b0, sys_rst = 1'b1, low_power_req = 1'b0;
    logic                rate_pin_lo = 1'b0, rate_pin_hi = 1'b0;
    mmrs_pkg::mmrs_mon_t mon = '0;
    mmrs_pkg::mmrs_cdr_t cdr_mode;
    logic                scl, sda_drv, sda_o, sda_oe, traffic_en, init_done, ok;
    logic [15:0]         d;
    int                  fail_count = 0, n_tests = 0, cyc = 0;
    wire                 sda_wire = sda_drv & ~sda_oe;
    always #10 clk = ~clk;
    mmrs_top #(.INIT_CYCLES(20)) u_mmrs_top (.clk(clk), .sys_rst(sys_rst), .scl_i(scl),
        .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe), .rate_pin_lo(rate_pin_lo),
        .rate_pin_hi(rate_pin_hi), .low_power_req(low_power_req), .mon(mon),
        .cdr_mode(cdr_mode), .traffic_en(traffic_en), .init_done(init_done));
    mmrs_host u_mmrs_host (.clk(clk), .sda(sda_wire), .scl(scl), .sda_drv(sda_drv));
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard: the whole run needs about 6900 cycles
    always @(negedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] mode(input mmrs_pkg::mmrs_cdr_mode_t t, r);
        return {12'h0, t, r};
    endfunction
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] v);
        u_mmrs_host.access(dev, a, 1'b0, v, d, ok);
        chk({15'h0, ok}, 16'h1);
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] a, input logic [15:0] exp);
        u_mmrs_host.access(dev, a, 1'b1, 8'h00, d, ok);
        chk({15'h0, ok}, 16'h1);
        chk(d, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        repeat (25) @(negedge clk);
        chk({12'h0, cdr_mode}, mode(mmrs_pkg::CDR_LOCK_10G, mmrs_pkg::CDR_LOCK_10G));
        chk({14'h0, init_done, traffic_en}, 16'h3);
        rd(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::RATE_SOFT_LO, 16'h0800);
        rd(mmrs_pkg::ID_DEV_ADDR, 8'h00, {mmrs_pkg::ID_BYTE0_RESET, 8'h00});
    endtask
    // clear both soft bits, then walk every pin combination
    task automatic t_rate();
        wr(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::RATE_SOFT_LO, 8'h00);
        wr(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::RATE_SOFT_HI, 8'h00);
        for (int i = 0; i < 4; i++) begin
            {rate_pin_hi, rate_pin_lo} = i[1:0];
            repeat (6) @(negedge clk);
            chk({12'h0, cdr_mode}, (i == 0) ? mode(mmrs_pkg::CDR_LOCK_8G5, mmrs_pkg::CDR_LOCK_8G5)
                : (i == 1) ? mode(mmrs_pkg::CDR_BYPASS, mmrs_pkg::CDR_BYPASS)
                : (i == 2) ? mode(mmrs_pkg::CDR_BYPASS, mmrs_pkg::CDR_LOCK_10G)
                : mode(mmrs_pkg::CDR_LOCK_10G, mmrs_pkg::CDR_LOCK_10G));
        end
        {rate_pin_hi, rate_pin_lo} = 2'b00;
        wr(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::RATE_SOFT_LO, mmrs_pkg::RATE_SOFT_RESET);
        repeat (4) @(negedge clk);
        chk({12'h0, cdr_mode}, mode(mmrs_pkg::CDR_BYPASS, mmrs_pkg::CDR_BYPASS));
        wr(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::RATE_SOFT_HI, mmrs_pkg::RATE_SOFT_RESET);
        repeat (4) @(negedge clk);
        chk({12'h0, cdr_mode}, mode(mmrs_pkg::CDR_LOCK_10G, mmrs_pkg::CDR_LOCK_10G));
    endtask
    // writable user bytes, then protected places that must keep their values
    task automatic t_memory();
        wr(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::USER_BASE, 8'ha5);
        wr(mmrs_pkg::DIAG_DEV_ADDR, 8'h82, 8'h5a);
        rd(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::USER_BASE, 16'ha55a);
        wr(mmrs_pkg::ID_DEV_ADDR, 8'h00, 8'hff);
        rd(mmrs_pkg::ID_DEV_ADDR, 8'h00, {mmrs_pkg::ID_BYTE0_RESET, 8'h00});
        wr(mmrs_pkg::DIAG_DEV_ADDR, 8'h00, 8'h00);
        rd(mmrs_pkg::DIAG_DEV_ADDR, 8'h00, mmrs_pkg::THR_ONE[63:48]);
    endtask
    // temperature above both high limits, receive power below both low limits
    task automatic t_monitor();
        mon = '{temp: 16'hc100, vcc: 16'h8000, bias: 16'h8000, tx_pwr: 16'h8000,
                rx_pwr: 16'h0800};
        repeat (4) @(negedge clk);
        rd(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::MON_BASE, 16'hc100);
        rd(mmrs_pkg::DIAG_DEV_ADDR, 8'h68, 16'h0800);
        rd(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::ALARM_BASE, 16'h8040);
        rd(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::WARN_BASE, 16'h8040);
    endtask
    // foreign address is ignored; low power keeps the bus alive
    task automatic t_addr_power();
        u_mmrs_host.access(7'h52, 8'h00, 1'b1, 8'h00, d, ok);
        chk({15'h0, ok}, 16'h0);
        low_power_req = 1'b1;
        repeat (6) @(negedge clk);
        chk({15'h0, traffic_en}, 16'h0);
        rd(mmrs_pkg::DIAG_DEV_ADDR, mmrs_pkg::USER_BASE, 16'ha55a);
        low_power_req = 1'b0;
        repeat (6) @(negedge clk);
        chk({15'h0, traffic_en}, 16'h1);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        t_power_up();
        t_rate();
        t_memory();
        t_monitor();
        t_addr_power();
        print_verdict();
    end
endmodule // tb
bind mmrs_top mmrs_assertions #(.INIT_CYCLES(INIT_CYCLES)) u_mmrs_assertions (.clk(clk),
    .sys_rst(sys_rst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .rate_pin_lo(rate_pin_lo), .rate_pin_hi(rate_pin_hi), .low_power_req(low_power_req),
    .cdr_mode(cdr_mode), .traffic_en(traffic_en), .init_done(init_done));
